// ---- logic/eepc_host.v ----
// Host controller driving the EEPROM byte-wide pins
`timescale 1ns/1ns
`include "eepc_map.vh"
module eepc_host #(
  parameter AW = 19,
  parameter PAGE_BITS = 7,
  parameter BLC_CYC = `EEPC_BLC_CYC,
  parameter WC_CYC = `EEPC_WC_CYC
) (
  input wire clk,
  input wire nrst,
  input wire req_valid,
  input wire req_write,
  input wire req_last,
  input wire [AW-1:0] req_addr,
  input wire [7:0] req_wdata,
  output reg req_ready,
  output reg rsp_valid,
  output reg [7:0] rsp_rdata,
  output reg prog_busy,
  output reg prog_timeout,
  output reg [AW-1:0] mem_addr,
  output reg mem_cs_n,
  output reg mem_oe_n,
  output reg mem_we_n,
  output reg [7:0] mem_dq_o,
  output reg mem_dq_oe,
  input wire [7:0] mem_dq_i
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_RD = 7'h02;
  localparam [6:0] S_RREL = 7'h04;
  localparam [6:0] S_WSET = 7'h08;
  localparam [6:0] S_WLOW = 7'h10;
  localparam [6:0] S_WHI = 7'h20;
  localparam [6:0] S_POLL = 7'h40;
  localparam integer ACC = `EEPC_ACC_CYC;
  localparam integer DF = `EEPC_DF_CYC;
  localparam integer WP = `EEPC_WP_CYC;
  localparam integer WPH = `EEPC_WPH_CYC;
  localparam integer GAP = 8;
  localparam [31:0] POLL_LIM = WC_CYC;
  localparam [31:0] BLC_LIM = BLC_CYC;
  // Margin covers take to strobe latency
  localparam [31:0] BLC_END = BLC_LIM - 32'd4;
  // ==========================================================
  // Input synchroniser
  reg [7:0] dq_s1_r;
  reg [7:0] dq_s2_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
    end else begin
      dq_s1_r <= mem_dq_i;
      dq_s2_r <= dq_s1_r;
    end
  end
  // ==========================================================
  // Sequencer
  reg [6:0] st_r;
  reg [15:0] cnt_r;
  reg [31:0] tmo_r;
  reg [31:0] blc_r;
  reg blc_run_r;
  reg page_open_r;
  reg [AW-1:0] page_r;
  reg [7:0] last_data_r;
  reg [AW-1:0] last_addr_r;
  reg pend_last_r;
  reg poll_ok_r;
  reg dirty_r;
  wire same_page;
  assign same_page = (req_addr[AW-1:PAGE_BITS] == page_r[AW-1:PAGE_BITS]);
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= S_IDLE;
      cnt_r <= 16'h0000;
      tmo_r <= 32'h0000_0000;
      blc_r <= 32'h0000_0000;
      blc_run_r <= 1'b0;
      page_open_r <= 1'b0;
      page_r <= {AW{1'b0}};
      last_data_r <= 8'h00;
      last_addr_r <= {AW{1'b0}};
      pend_last_r <= 1'b0;
      poll_ok_r <= 1'b0;
      dirty_r <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      prog_busy <= 1'b0;
      prog_timeout <= 1'b0;
      mem_addr <= {AW{1'b0}};
      mem_cs_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_we_n <= 1'b1;
      mem_dq_o <= 8'h00;
      mem_dq_oe <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      if (blc_run_r) begin
        if (blc_r >= BLC_END) begin
          blc_run_r <= 1'b0;
          page_open_r <= 1'b0;
        end else begin
          blc_r <= blc_r + 32'd1;
        end
      end
      case (st_r)
        S_IDLE: begin
          if (page_open_r && blc_run_r && !req_valid) begin
            st_r <= S_IDLE;
          end else if (req_valid && !req_ready) begin
            if (dirty_r && !(page_open_r && req_write && same_page)) begin
              page_open_r <= 1'b0;
              pend_last_r <= 1'b0;
              st_r <= S_POLL;
              cnt_r <= 16'h0000;
              tmo_r <= 32'h0000_0000;
              prog_busy <= 1'b1;
            end else if (req_write) begin
              mem_addr <= req_addr;
              dirty_r <= 1'b1;
              mem_dq_o <= req_wdata;
              mem_dq_oe <= 1'b1;
              last_data_r <= req_wdata;
              last_addr_r <= req_addr;
              page_r <= req_addr;
              pend_last_r <= req_last;
              cnt_r <= 16'h0000;
              st_r <= S_WSET;
            end else begin
              mem_addr <= req_addr;
              mem_dq_oe <= 1'b0;
              mem_cs_n <= 1'b0;
              mem_oe_n <= 1'b0;
              cnt_r <= 16'h0000;
              st_r <= S_RD;
            end
          end
        end
        S_RD: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r >= ACC[15:0]) begin
            rsp_rdata <= dq_s2_r;
            mem_cs_n <= 1'b1;
            mem_oe_n <= 1'b1;
            cnt_r <= 16'h0000;
            st_r <= S_RREL;
          end
        end
        S_RREL: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r >= DF[15:0]) begin
            rsp_valid <= 1'b1;
            req_ready <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        S_WSET: begin
          // write enable only with output enable high
          mem_oe_n <= 1'b1;
          mem_cs_n <= 1'b0;
          mem_we_n <= 1'b0;
          cnt_r <= 16'h0000;
          blc_r <= 32'h0000_0000;
          blc_run_r <= 1'b1;
          page_open_r <= 1'b1;
          st_r <= S_WLOW;
        end
        S_WLOW: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r >= WP[15:0]) begin
            mem_we_n <= 1'b1;
            mem_cs_n <= 1'b1;
            cnt_r <= 16'h0000;
            st_r <= S_WHI;
          end
        end
        S_WHI: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r >= WPH[15:0]) begin
            mem_dq_oe <= 1'b0;
            req_ready <= 1'b1;
            cnt_r <= 16'h0000;
            tmo_r <= 32'h0000_0000;
            if (pend_last_r) begin
              page_open_r <= 1'b0;
              prog_busy <= 1'b1;
              st_r <= S_POLL;
            end else begin
              st_r <= S_IDLE;
            end
          end
        end
        S_POLL: begin
          tmo_r <= tmo_r + 32'd1;
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == 16'h0000) begin
            mem_addr <= last_addr_r;
            mem_cs_n <= 1'b0;
            mem_oe_n <= 1'b0;
          end else if (cnt_r == ACC[15:0]) begin
            mem_cs_n <= 1'b1;
            mem_oe_n <= 1'b1;
            poll_ok_r <= (dq_s2_r[`EEPC_POLL_BIT] ==
              last_data_r[`EEPC_POLL_BIT]);
          end else if (cnt_r == ACC[15:0] + DF[15:0] + 16'h0001) begin
            if (poll_ok_r) begin
              prog_busy <= 1'b0;
              blc_run_r <= 1'b0;
              dirty_r <= 1'b0;
              st_r <= S_IDLE;
            end else if (tmo_r >= POLL_LIM + BLC_LIM) begin
              prog_busy <= 1'b0;
              prog_timeout <= 1'b1;
              dirty_r <= 1'b0;
              st_r <= S_IDLE;
            end
          end else if (cnt_r >= ACC[15:0] + DF[15:0] + GAP[15:0]) begin
            cnt_r <= 16'h0000;
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule // eepc_host

// ---- logic/eepc_map.vh ----
// Constants for the EEPROM host port controller
// What this block does
// - Next page byte loaded within load timeout
// - Low address bits may differ across page loads
// - Same page and block address every load
// - Poll last address until top bit matches or the poll time limit runs out
`ifndef EEPC_MAP_VH
`define EEPC_MAP_VH
`define EEPC_CLK_MHZ 50
`define EEPC_T_ACC_NS 300
`define EEPC_T_DF_NS 70
`define EEPC_T_WP_NS 150
`define EEPC_T_WPH_NS 50
`define EEPC_T_BLC_US 150
`define EEPC_T_WC_MS 10
`define EEPC_ACC_CYC ((`EEPC_T_ACC_NS * `EEPC_CLK_MHZ + 999) / 1000 + 1)
`define EEPC_DF_CYC ((`EEPC_T_DF_NS * `EEPC_CLK_MHZ + 999) / 1000)
`define EEPC_WP_CYC ((`EEPC_T_WP_NS * `EEPC_CLK_MHZ + 999) / 1000)
`define EEPC_WPH_CYC ((`EEPC_T_WPH_NS * `EEPC_CLK_MHZ + 999) / 1000)
`define EEPC_BLC_CYC (`EEPC_T_BLC_US * `EEPC_CLK_MHZ)
`define EEPC_WC_CYC (`EEPC_T_WC_MS * 1000 * `EEPC_CLK_MHZ)
`define EEPC_POLL_BIT 7
`endif

// ---- verification/eepc_host_monitor.sv ----
// Checker for the EEPROM host port pins
`timescale 1ns/1ns
module eepc_host_monitor #(parameter AW = 19) (
  input wire clk,
  input wire nrst,
  input wire [AW-1:0] mem_addr,
  input wire mem_cs_n,
  input wire mem_oe_n,
  input wire mem_we_n,
  input wire [7:0] mem_dq_o,
  input wire mem_dq_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wr_fall;
    $fell(mem_we_n) && !mem_cs_n;
  endsequence
  sequence s_rd_fall;
    $fell(mem_oe_n) && !mem_cs_n;
  endsequence
  AST_WR_OE: assert property (!mem_we_n |-> mem_oe_n)
    else $error("write strobe with oe low");
  AST_WR_PULSE: assert property (s_wr_fall |-> !mem_we_n[*8])
    else $error("write pulse short");
  AST_WR_ADDR: assert property (!mem_we_n |-> $stable(mem_addr))
    else $error("address moved in write");
  AST_WR_DATA: assert property (!mem_we_n |-> mem_dq_oe)
    else $error("data not driven in write");
  AST_WR_HOLD: assert property ($rose(mem_we_n) |->
    mem_dq_oe && $stable(mem_dq_o) ##0 mem_we_n[*3])
    else $error("data or high time short");
  AST_RD_NODRV: assert property (!mem_oe_n |-> !mem_dq_oe && mem_we_n)
    else $error("host drives in read");
  AST_RD_ACC: assert property (s_rd_fall |->
    !mem_oe_n[*8] ##1 !mem_oe_n[*8])
    else $error("read shorter than access");
  AST_RD_REL: assert property ($rose(mem_oe_n) |-> mem_oe_n[*4])
    else $error("bus reused before release");
endmodule // eepc_host_monitor

// ---- verification/eepc_host_tb_top.sv ----
// Testbench for the EEPROM host port controller
`timescale 1ns/1ns
module eepc_host_tb_top;
  reg clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  reg req_last = 1'b0;
  reg [18:0] req_addr = 19'h00000;
  reg [7:0] req_wdata = 8'h00;
  wire req_ready, rsp_valid, prog_busy, prog_timeout;
  wire mem_cs_n, mem_oe_n, mem_we_n, mem_dq_oe;
  wire [18:0] mem_addr;
  wire [7:0] rsp_rdata, mem_dq_o, dq_dev, dq;
  integer err_total = 0, checks_done = 0, i;
  always #10 clk = ~clk;
  assign dq = mem_dq_oe ? mem_dq_o : dq_dev;
  eepc_host #(.BLC_CYC(50), .WC_CYC(400)) DUT (.clk(clk), .nrst(nrst),
    .req_valid(req_valid), .req_write(req_write), .req_last(req_last),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .prog_busy(prog_busy),
    .prog_timeout(prog_timeout), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n),
    .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .mem_dq_o(mem_dq_o),
    .mem_dq_oe(mem_dq_oe), .mem_dq_i(dq));
  eepc_mem_model #(.BLC(50), .WC(300)) u_mem (.clk(clk), .addr(mem_addr),
    .cs_n(mem_cs_n), .oe_n(mem_oe_n), .we_n(mem_we_n), .din(dq),
    .dout(dq_dev));
  task end_of_test;
    begin
      $display("mismatches %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wt(input busy);
    integer n;
    begin
      n = 0;
      while ((busy ? prog_busy : req_ready) !== ~busy) begin
        @(negedge clk);
        n = n + 1;
        if (n > 3000) begin
          chk(8'h00, 8'hFF);
          end_of_test;
        end
      end
    end
  endtask
  task req(input w, input l, input [18:0] a, input [7:0] d);
    begin
      @(negedge clk);
      req_valid = 1'b1;
      req_write = w;
      req_last = l;
      req_addr = a;
      req_wdata = d;
      wt(1'b0);
      chk({7'h00, rsp_valid}, {7'h00, ~w});
      req_valid = 1'b0;
    end
  endtask
  task t_byte;
    begin
      req(1'b1, 1'b1, 19'h00005, 8'hA5);
      repeat (2) @(negedge clk);
      chk({7'h00, prog_busy}, 8'h01);
      wt(1'b1);
      req(1'b0, 1'b0, 19'h00005, 8'h00);
      chk(rsp_rdata, 8'hA5);
    end
  endtask
  task t_page;
    begin
      for (i = 0; i < 4; i = i + 1)
        req(1'b1, i == 3, 19'h0017C + i, 8'h7E + i);
      wt(1'b1);
      for (i = 0; i < 4; i = i + 1) begin
        req(1'b0, 1'b0, 19'h0017C + i, 8'h00);
        chk(rsp_rdata, 8'h7E + i);
      end
    end
  endtask
  task t_switch;
    begin
      req(1'b1, 1'b0, 19'h00200, 8'h3C);
      req(1'b1, 1'b1, 19'h00280, 8'hC3);
      wt(1'b1);
      req(1'b0, 1'b0, 19'h00200, 8'h00);
      chk(rsp_rdata, 8'h3C);
      req(1'b0, 1'b0, 19'h00280, 8'h00);
      chk(rsp_rdata, 8'hC3);
    end
  endtask
  task t_expire;
    begin
      req(1'b1, 1'b0, 19'h00300, 8'h5A);
      repeat (80) @(negedge clk);
      req(1'b0, 1'b0, 19'h00300, 8'h00);
      chk(rsp_rdata, 8'h5A);
    end
  endtask
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    t_byte;
    t_page;
    t_switch;
    t_expire;
    chk({7'h00, prog_timeout}, 8'h00);
    end_of_test;
  end
endmodule // eepc_host_tb_top
bind eepc_host eepc_host_monitor #(.AW(AW)) u_mon (.clk(clk), .nrst(nrst),
  .mem_addr(mem_addr), .mem_cs_n(mem_cs_n), .mem_oe_n(mem_oe_n),
  .mem_we_n(mem_we_n), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));

// ---- verification/eepc_mem_model.sv ----
// Behavioural EEPROM device model
`timescale 1ns/1ns
module eepc_mem_model #(parameter BLC = 50, parameter WC = 300) (
  input wire clk,
  input wire [18:0] addr,
  input wire cs_n,
  input wire oe_n,
  input wire we_n,
  input wire [7:0] din,
  output wire [7:0] dout
);
  reg [7:0] mem [0:1023];
  reg [7:0] pg [0:127];
  reg [127:0] pv = 128'h0;
  reg [9:0] la;
  reg [7:0] ld = 8'h00;
  reg [7:0] lv = 8'h00;
  reg wf = 1'b0;
  integer t = 0, w = 0, a = 0, i;
  wire wr = !cs_n && !we_n && oe_n;
  wire rd = !cs_n && !oe_n && we_n;
  assign dout = (rd && a > 12) ?
    ((t > 0 || w > 0) ? ld ^ 8'h80 : mem[addr[9:0]]) : ~lv;
  always @(posedge clk) begin
    wf <= wr;
    lv <= dout;
    a <= rd ? a + 1 : 0;
    if (wr && !wf) begin
      la <= addr[9:0];
      t <= BLC;
    end else if (!wr && wf) begin
      pg[la[6:0]] <= din;
      pv[la[6:0]] <= 1'b1;
      ld <= din;
    end else if (t > 0) begin
      t <= t - 1;
      if (t == 1)
        w <= WC;
    end else if (w > 0) begin
      w <= w - 1;
      if (w == 1) begin
        for (i = 0; i < 128; i = i + 1)
          if (pv[i])
            mem[{la[9:7], i[6:0]}] <= pg[i];
        pv <= 128'h0;
      end
    end
  end
endmodule // eepc_mem_model
